// >>> hdl/emb_ctrl.sv
// How it works
// - The three space selects idle high and only the one for the addressed space goes low.
// - A space select is low only while a valid address is driven on the bus.
// - The space selects float in hold and while the output-float input is low.
// - The memory strobe idles high and goes low only for data or program accesses.
// - The memory strobe floats in hold and while the output-float input is low.
// - The external ready input marks when the current access may complete.
// - The direction line idles high for read and goes low only during a write.
// - The direction line floats in hold and while the output-float input is low.
// - Mode pin low at reset maps the internal ROM into the top 16K words of the first program page.
// - Mode pin high at reset removes the ROM so those addresses go external.
// - The mode pin is caught only during reset and a mode bit may later override it.
// - An asserted hold request is acknowledged and all bus outputs float on that same edge.
`timescale 1ns/1ps
`include "emb_params.svh"
module emb_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rom_map_mode_pin,
    input wire logic ready,
    input wire logic hold_n,
    input wire logic off_n,
    input wire logic mode_wr,
    input wire logic mode_wdata,
    input wire logic req_valid,
    output logic req_ready,
    input wire emb_pkg::emb_req_t req,
    output logic done,
    output logic [15:0] rdata,
    output logic rom_hit,
    output logic microcomputer_mode,
    output logic holda_n,
    output logic [2:0] space_sel_o,
    output logic [2:0] space_sel_oe,
    output logic memory_strobe_o,
    output logic memory_strobe_oe,
    output logic rd_wr_o,
    output logic rd_wr_oe,
    output logic [22:0] addr_o,
    output logic addr_oe,
    output logic [15:0] data_o,
    output logic data_oe,
    input wire logic [15:0] data_i
);
    emb_pkg::emb_state_s_t s;
    emb_pkg::emb_state_s_t next_s;
    logic ready_s;
    logic hold_s;
    logic float_all;
    logic [1:0] mode_pin_sync;

    // ROM occupies the top 16K words of the first program page
    function automatic logic in_rom(input logic [22:0] a);
        in_rom = (a[22:16] == 7'h00) && (a[15:0] >= `EMB_ROM_BASE);
    endfunction : in_rom

    ////////////////////////////////////////////////////////////////////////////
    assign ready_s = s.ready_sync[1];
    assign hold_s = ~s.hold_sync[1];
    // Off is asynchronous by nature, so it gates the enables without a clock
    assign float_all = s.holda | ~off_n;

    // Strap sampler runs through reset so the pin level is settled at release
    always_ff @(posedge ref_clk) begin
        mode_pin_sync <= {mode_pin_sync[0], rom_map_mode_pin};
    end

    assign microcomputer_mode = ~s.mode_bit;
    assign rom_hit = req_valid && req.space == emb_pkg::EMB_SP_PROG &&
        ~s.mode_bit && in_rom(req.addr);
    assign req_ready = (s.st == emb_pkg::EMB_IDLE) && ~hold_s && ~rom_hit;
    assign done = s.done;
    assign rdata = s.rdata;
    assign holda_n = ~s.holda;
    assign space_sel_o = s.bus.sel_n;
    assign space_sel_oe = {3{~float_all}};
    assign memory_strobe_o = s.bus.strobe_n;
    assign memory_strobe_oe = ~float_all;
    assign rd_wr_o = s.bus.rd_wr;
    assign rd_wr_oe = ~float_all;
    assign addr_o = s.bus.addr;
    assign addr_oe = ~float_all;
    assign data_o = s.bus.wdata;
    assign data_oe = s.bus.data_oe & ~float_all;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.ready_sync = {s.ready_sync[0], ready};
        next_s.hold_sync = {s.hold_sync[0], hold_n};
        // First edge after release takes the pin; later only software changes it
        if (!s.rst_seen) begin
            next_s.rst_seen = 1'b1;
            next_s.mode_bit = mode_pin_sync[1];
        end else if (mode_wr) begin
            next_s.mode_bit = mode_wdata;
        end
        case (s.st)
            emb_pkg::EMB_IDLE: begin
                if (hold_s) begin
                    next_s.holda = 1'b1;
                    next_s.st = emb_pkg::EMB_HOLD;
                end else if (req_valid && req_ready) begin
                    next_s.bus.addr = req.addr;
                    next_s.bus.wdata = req.wdata;
                    next_s.bus.sel_n = `EMB_SEL_IDLE;
                    next_s.bus.sel_n[req.space] = 1'b0;
                    next_s.bus.strobe_n = (req.space == emb_pkg::EMB_SP_IO);
                    next_s.bus.rd_wr = ~req.write;
                    next_s.bus.data_oe = req.write;
                    next_s.st = emb_pkg::EMB_ADDR;
                end
            end
            emb_pkg::EMB_ADDR: begin
                next_s.st = emb_pkg::EMB_WAIT;
            end
            emb_pkg::EMB_WAIT: begin
                // Bus stays frozen until ready is seen high
                if (ready_s) begin
                    next_s.rdata = data_i;
                    next_s.done = 1'b1;
                    next_s.bus.sel_n = `EMB_SEL_IDLE;
                    next_s.bus.strobe_n = `EMB_STRB_IDLE;
                    next_s.bus.rd_wr = `EMB_DIR_READ;
                    next_s.bus.data_oe = 1'b0;
                    next_s.st = emb_pkg::EMB_IDLE;
                end
            end
            emb_pkg::EMB_HOLD: begin
                if (!hold_s) begin
                    next_s.holda = 1'b0;
                    next_s.st = emb_pkg::EMB_IDLE;
                end
            end
            default: begin
                next_s.st = emb_pkg::EMB_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= emb_pkg::EMB_IDLE;
            s.bus.sel_n <= `EMB_SEL_IDLE;
            s.bus.strobe_n <= `EMB_STRB_IDLE;
            s.bus.rd_wr <= `EMB_DIR_READ;
            // A cleared hold synchroniser would fake a hold request at release
            s.hold_sync <= `EMB_HOLD_SYNC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_sel_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $countones(~s.bus.sel_n) <= 1)
        else $error("more than one space select low");
    a_sel_addr_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.bus.sel_n != `EMB_SEL_IDLE) |-> (s.st inside {emb_pkg::EMB_ADDR, emb_pkg::EMB_WAIT}))
        else $error("space select low outside an access");
    a_float_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s.holda |-> (space_sel_oe == 3'h0 && !memory_strobe_oe && !rd_wr_oe && !addr_oe))
        else $error("outputs driven in hold");
    a_strobe_io: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s.bus.strobe_n |-> s.bus.sel_n[emb_pkg::EMB_SP_IO])
        else $error("memory strobe on io access");
    a_strobe_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !off_n |-> !memory_strobe_oe)
        else $error("strobe driven while off low");
    a_ready_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_WAIT && ready_s) |=> done)
        else $error("ready did not end the cycle");
    a_dir_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s.bus.rd_wr |-> s.bus.data_oe)
        else $error("direction low without a write");
    a_dir_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!off_n || s.holda) |-> !rd_wr_oe)
        else $error("direction driven while floated");
    a_rom_internal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rom_hit) |-> !req_ready)
        else $error("rom access went external");
    a_hold_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_IDLE && hold_s) |=> s.holda)
        else $error("hold not acknowledged");
    a_wait_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_WAIT && !ready_s) |=> $stable(s.bus))
        else $error("bus changed during wait");

    ////////////////////////////////////////////////////////////////////////////
    // Float, mode and phase checks
    a_sel_float_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !off_n |-> (space_sel_oe == 3'h0))
        else $error("space selects driven while off low");
    a_bus_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s.holda |-> (!addr_oe && !data_oe))
        else $error("address or data driven in hold");
    a_hold_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_HOLD) |-> (s.holda && !holda_n))
        else $error("hold state without acknowledge");
    a_rom_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req_valid && req.space == emb_pkg::EMB_SP_PROG && s.mode_bit) |-> !rom_hit)
        else $error("rom claimed in microprocessor mode");
    a_mode_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s.rst_seen |=> (s.mode_bit == $past(mode_pin_sync[1])))
        else $error("mode not taken from the strap");
    a_mode_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.rst_seen && !mode_wr) |=> $stable(s.mode_bit))
        else $error("mode changed without a write");
    a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done |=> !done)
        else $error("done longer than one cycle");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st inside {emb_pkg::EMB_IDLE, emb_pkg::EMB_HOLD}) |->
            (s.bus.rd_wr && s.bus.strobe_n && s.bus.sel_n == `EMB_SEL_IDLE))
        else $error("control lines active while idle");
    a_strobe_mem: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_ADDR && s.bus.sel_n[emb_pkg::EMB_SP_IO]) |-> !s.bus.strobe_n)
        else $error("memory access without strobe");
    a_refuse_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st != emb_pkg::EMB_IDLE) |-> !req_ready)
        else $error("request accepted while busy");
    a_addr_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.st == emb_pkg::EMB_ADDR) |=> (s.st == emb_pkg::EMB_WAIT))
        else $error("address phase not followed by wait");
endmodule : emb_ctrl

// >>> include/emb_params.svh
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
// Address and data widths of the external bus
`define EMB_ADDR_W 23
`define EMB_DATA_W 16
// On-chip ROM window: top 16K words of the 64K program page
`define EMB_ROM_BASE 16'hc000
`define EMB_ROM_HI_BITS 2
// Reset values of the control outputs
`define EMB_SEL_IDLE 3'h7
`define EMB_STRB_IDLE 1'h1
`define EMB_DIR_READ 1'h1
// Hold request synchroniser idles at the released level of its pin
`define EMB_HOLD_SYNC_IDLE 2'h3
`endif

// >>> include/emb_pkg.sv
package emb_pkg;
    typedef enum logic [1:0] {
        EMB_SP_DATA,
        EMB_SP_PROG,
        EMB_SP_IO
    } emb_space_t;

    typedef enum {
        EMB_IDLE,
        EMB_ADDR,
        EMB_WAIT,
        EMB_HOLD
    } emb_state_t;

    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] wdata;
        logic write;
        emb_space_t space;
    } emb_req_t;

    typedef struct packed {
        logic [2:0] sel_n;
        logic strobe_n;
        logic rd_wr;
        logic [22:0] addr;
        logic [15:0] wdata;
        logic data_oe;
    } emb_bus_t;

    typedef struct packed {
        emb_state_t st;
        emb_bus_t bus;
        logic [15:0] rdata;
        logic done;
        logic holda;
        logic mode_latched;
        logic mode_bit;
        logic rst_seen;
        logic [1:0] ready_sync;
        logic [1:0] hold_sync;
    } emb_state_s_t;
endpackage : emb_pkg

// >>> tb/emb_mem_model.sv
`timescale 1ns/1ps
module emb_mem_model (
    input wire logic ref_clk,
    input wire logic [2:0] space_sel_o,
    input wire logic rd_wr_o,
    input wire logic [22:0] addr_o,
    input wire logic [15:0] data_o,
    input wire logic [3:0] lat,
    output logic ready,
    output logic [15:0] data_i
);
    logic [15:0] mem [16];
    logic [7:0] cnt = 8'h0;
    wire logic sel = space_sel_o != 3'h7;
    // Ready only after the access has waited lat cycles
    assign ready = sel && cnt >= {4'h0, lat};
    // Released bus shows the inverse so a stale word never passes as read data
    assign data_i = (sel && rd_wr_o) ? mem[addr_o[3:0]] : ~mem[addr_o[3:0]];
    always @(posedge ref_clk) begin
        cnt <= sel ? cnt + 8'h1 : 8'h0;
        if (sel && !rd_wr_o) begin
            mem[addr_o[3:0]] <= data_o;
        end
    end
endmodule : emb_mem_model

// >>> tb/external_memory_bus_control_tb.sv
`timescale 1ns/1ps
module external_memory_bus_control_tb;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
    typedef struct packed {logic [1:0] sp; logic wr; logic [22:0] a; logic [15:0] d;
        logic [2:0] sel; logic strb;} emb_row_t;
    logic ref_clk = 1'b0, rst_n = 1'b0, rom_map_mode_pin = 1'b0, hold_n = 1'b1, off_n = 1'b1;
    logic mode_wr = 1'b0, mode_wdata = 1'b0, req_valid = 1'b0;
    logic ready, req_ready, done, rom_hit, microcomputer_mode, holda_n;
    logic memory_strobe_o, memory_strobe_oe, rd_wr_o, rd_wr_oe, addr_oe, data_oe;
    logic [2:0] space_sel_o, space_sel_oe;
    logic [22:0] addr_o;
    logic [15:0] rdata, data_o, data_i;
    logic [3:0] lat = 4'h1;
    emb_pkg::emb_req_t req = '0;
    int failures = 0, check_count = 0, n;
    emb_row_t rows [6] = '{
        '{2'h0, 1'b1, 23'h000001, 16'h1234, 3'h6, 1'b0},
        '{2'h0, 1'b0, 23'h000001, 16'h1234, 3'h6, 1'b0},
        '{2'h1, 1'b1, 23'h000002, 16'habcd, 3'h5, 1'b0},
        '{2'h1, 1'b0, 23'h000002, 16'habcd, 3'h5, 1'b0},
        '{2'h2, 1'b1, 23'h000003, 16'h5a5a, 3'h3, 1'b1},
        '{2'h2, 1'b0, 23'h000003, 16'h5a5a, 3'h3, 1'b1}};
    emb_ctrl dut (.ref_clk, .rst_n, .rom_map_mode_pin, .ready, .hold_n, .off_n, .mode_wr,
        .mode_wdata, .req_valid, .req_ready, .req, .done, .rdata, .rom_hit, .microcomputer_mode,
        .holda_n, .space_sel_o, .space_sel_oe, .memory_strobe_o, .memory_strobe_oe, .rd_wr_o,
        .rd_wr_oe, .addr_o, .addr_oe, .data_o, .data_oe, .data_i);
    emb_mem_model mem (.ref_clk, .space_sel_o, .rd_wr_o, .addr_o, .data_o, .lat, .ready,
        .data_i);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task tally_and_finish;
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task do_reset(input logic pin);
        @(negedge ref_clk);
        rst_n = 1'b0;
        rom_map_mode_pin = pin;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : do_reset
    task access(input emb_row_t r);
        n = 0;
        req = '{r.a, r.d, r.wr, emb_pkg::emb_space_t'(r.sp)};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        `CHK("sel", r.sel, space_sel_o)
        `CHK("strobe", r.strb, memory_strobe_o)
        `CHK("dir", !r.wr, rd_wr_o)
        `CHK("addr", r.a, addr_o)
        `CHK("addr_oe", 1'b1, addr_oe)
        `CHK("data_oe", r.wr, data_oe)
        if (r.wr) `CHK("wdata", r.d, data_o)
        while (done !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("done", 1'b1, done)
        if (!r.wr) `CHK("rdata", r.d, rdata)
        `CHK("sel_end", 3'h7, space_sel_o)
    endtask : access
    initial begin
        do_reset(1'b0);
        `CHK("idle_sel", 3'h7, space_sel_o)
        `CHK("idle_strb", 1'b1, memory_strobe_o)
        `CHK("idle_dir", 1'b1, rd_wr_o)
        `CHK("mc_mode", 1'b1, microcomputer_mode)
        foreach (rows[i]) access(rows[i]);
        // Slow device must stretch the cycle and still return the word
        lat = 4'h6;
        access(rows[3]);
        // Six device waits, two ready sync stages and the edge that registers done
        `CHK("stretch_len", 32'h9, n)
        lat = 4'h1;
        // Held across an edge so a wrongly taken ROM access shows on the selects
        req = '{23'h00c000, 16'h0, 1'b0, emb_pkg::EMB_SP_PROG};
        req_valid = 1'b1;
        @(negedge ref_clk);
        `CHK("rom_hit", 1'b1, rom_hit)
        `CHK("rom_refused", 1'b0, req_ready)
        `CHK("rom_no_sel", 3'h7, space_sel_o)
        req_valid = 1'b0;
        do_reset(1'b1);
        `CHK("mp_mode", 1'b0, microcomputer_mode)
        rom_map_mode_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK("pin_ignored", 1'b0, microcomputer_mode)
        access('{2'h1, 1'b0, 23'h00c002, 16'habcd, 3'h5, 1'b0});
        mode_wr = 1'b1;
        @(negedge ref_clk);
        mode_wr = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK("override", 1'b1, microcomputer_mode)
        hold_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK("holda", 1'b0, holda_n)
        `CHK("hold_sel_oe", 3'h0, space_sel_oe)
        `CHK("hold_strb_oe", 1'b0, memory_strobe_oe)
        `CHK("hold_dir_oe", 1'b0, rd_wr_oe)
        `CHK("hold_addr_oe", 1'b0, addr_oe)
        hold_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        `CHK("drive_sel_oe", 3'h7, space_sel_oe)
        off_n = 1'b0;
        @(negedge ref_clk);
        `CHK("off_sel_oe", 3'h0, space_sel_oe)
        `CHK("off_strb_oe", 1'b0, memory_strobe_oe)
        `CHK("off_dir_oe", 1'b0, rd_wr_oe)
        off_n = 1'b1;
        @(negedge ref_clk);
        `CHK("on_strb_oe", 1'b1, memory_strobe_oe)
        tally_and_finish();
    end
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end
endmodule : external_memory_bus_control_tb
